// [core/mvo_serial_out.sv]
// Measured-value serial output: AXI4-Lite registers, ASCII record framer and serial port.
// ==========================================================
// Behaviour
// (RQ1) Remote switch or received Ctrl B sends all shown positions in current mode.
// (RQ2) Linear record starts with axis letter, equals sign, then plus or minus.
// (RQ3) Linear record has two to seven integer digits, then a decimal point.
// (RQ4) Linear record then has one to six fractional digits.
// (RQ5) Unit follows: space for millimetres, double quote for inches.
// (RQ6) Kind letter R or D, lower case in distance-to-go mode.
// (RQ7) Every record ends with carriage return then line feed.
// (RQ8) Rotary record: letter, equals, sign, four to eight digits, point, zero to four.
// (RQ9) Rotary record: space for unit, then W, lower case in distance-to-go mode.
// (RQ10) Every character sent or received is plain ASCII text.
// (RQ11) Raw character stream; no packets, acknowledgements or retransmission.
// (RQ12) The computer must be capturing before the readout begins sending.
// (RQ13) The computer sends its file only after the readout is ready to receive.
// (RQ14) Rate selectable from 300 to 115200 baud; setting is retained.
// (RQ15) Parity none, even or odd; seven or eight data bits; one or two stops.
// (RQ16) Zero to nine extra carriage returns close a transmission; zero initially.
// (RQ17) Characters are sent only while the far end signals ready.
// (RQ18) Received code 0x02 acts exactly like a remote switch activation.
// (RQ19) Axis records go out whole, one after another, in axis order.
`timescale 1ns/10ps
`include "mvo_map.svh"
module mvo_serial_out #(
   parameter int NUM_AXES = 3,
   parameter int CLK_HZ = `MVO_CLK_HZ
) (
   input wire logic clk, // System clock, 200 MHz.
   input wire logic sys_rst, // Synchronous reset, active high.
   input wire logic [11:0] s_axi_awaddr, // Write address.
   input wire logic s_axi_awvalid, // Write address valid.
   output logic s_axi_awready, // Write address ready.
   input wire logic [31:0] s_axi_wdata, // Write data.
   input wire logic [3:0] s_axi_wstrb, // Write byte enables.
   input wire logic s_axi_wvalid, // Write data valid.
   output logic s_axi_wready, // Write data ready.
   output logic [1:0] s_axi_bresp, // Write response.
   output logic s_axi_bvalid, // Write response valid.
   input wire logic s_axi_bready, // Write response ready.
   input wire logic [11:0] s_axi_araddr, // Read address.
   input wire logic s_axi_arvalid, // Read address valid.
   output logic s_axi_arready, // Read address ready.
   output logic [31:0] s_axi_rdata, // Read data.
   output logic [1:0] s_axi_rresp, // Read response.
   output logic s_axi_rvalid, // Read data valid.
   input wire logic s_axi_rready, // Read data ready.
   input wire logic remoteSwitch, // Remote switch pin, high when closed.
   input wire logic serRxd, // Serial receive pin, idle high.
   input wire logic peerReady, // Far end ready to accept characters.
   output logic serTxd, // Serial transmit pin, idle high.
   output logic rxReady // Readout ready to receive characters.
);
   initial if (NUM_AXES < 1 || NUM_AXES > 3) $error("mvo_serial_out: NUM_AXES must be 1 to 3");
   // ==========================================================
   // Pin synchronisers
   logic [1:0] swSync_ff, rxdSync_ff, rdySync_ff;
   logic swLast_ff;
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         swSync_ff <= 2'b00;
         rxdSync_ff <= 2'b11;
         rdySync_ff <= 2'b00;
         swLast_ff <= 1'b0;
      end else begin
         swSync_ff <= {swSync_ff[0], remoteSwitch};
         rxdSync_ff <= {rxdSync_ff[0], serRxd};
         rdySync_ff <= {rdySync_ff[0], peerReady};
         swLast_ff <= swSync_ff[1];
      end
   end
   // ==========================================================
   // Registers
   logic [31:0] ctrl_ff;
   logic [17:0] axCfg_ff [NUM_AXES];
   logic [31:0] valInt_ff [NUM_AXES];
   logic [23:0] valFrac_ff [NUM_AXES];
   logic rxFault_ff;
   logic [7:0] lastRx_ff, sendCnt_ff;
   mvo_pkg::mvo_frame_t frame;
   assign frame = mvo_pkg::mvo_frame_t'(ctrl_ff[7:0]);
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
      input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            r[b * 8 +: 8] = d[b * 8 +: 8];
         end
      end
      return r;
   endfunction : merge
   // Returns axis index and field (0 cfg, 1 int, 2 frac) or not mapped.
   function automatic logic decodeAxis(input logic [11:0] a, output int ax, output int fld);
      logic [11:0] rel;
      rel = a - `MVO_AXIS_BASE;
      ax = int'(rel[11:4]);
      fld = int'(rel[3:2]);
      return (a >= `MVO_AXIS_BASE) && (ax < NUM_AXES) && (fld < 3);
   endfunction : decodeAxis
   // ==========================================================
   // AXI4-Lite write channel; address and data may arrive in either order.
   logic awHeld_ff, wHeld_ff;
   logic [11:0] awAddr_ff;
   logic [31:0] wData_ff;
   logic [3:0] wStrb_ff;
   logic doWrite, wrHit, wAx, swTrig, statClear;
   int wAxIdx, wFld;
   assign s_axi_awready = !awHeld_ff && !s_axi_bvalid;
   assign s_axi_wready = !wHeld_ff && !s_axi_bvalid;
   assign doWrite = awHeld_ff && wHeld_ff && !s_axi_bvalid;
   always_comb wAx = decodeAxis(awAddr_ff, wAxIdx, wFld);
   assign wrHit = wAx || awAddr_ff == `MVO_CTRL_OFS || awAddr_ff == `MVO_STAT_OFS;
   assign swTrig = doWrite && awAddr_ff == `MVO_CTRL_OFS && wStrb_ff[2]
      && wData_ff[`MVO_TRIG_BIT];
   assign statClear = doWrite && awAddr_ff == `MVO_STAT_OFS && wStrb_ff[0] && wData_ff[1];
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         awHeld_ff <= 1'b0;
         wHeld_ff <= 1'b0;
         awAddr_ff <= 12'h0;
         wData_ff <= 32'h0;
         wStrb_ff <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'b00;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awHeld_ff <= 1'b1;
            awAddr_ff <= {s_axi_awaddr[11:2], 2'b00};
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHeld_ff <= 1'b1;
            wData_ff <= s_axi_wdata;
            wStrb_ff <= s_axi_wstrb;
         end
         if (doWrite) begin
            awHeld_ff <= 1'b0;
            wHeld_ff <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wrHit ? 2'b00 : 2'b10;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ctrl_ff <= `MVO_CTRL_RST;
      end else if (doWrite && awAddr_ff == `MVO_CTRL_OFS) begin
         ctrl_ff <= merge(ctrl_ff, wData_ff, wStrb_ff) & 32'h0000_ffff; // RQ14 RQ15 RQ16
      end
   end
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         for (int i = 0; i < NUM_AXES; i++) begin
            axCfg_ff[i] <= 18'h0;
            valInt_ff[i] <= 32'h0;
            valFrac_ff[i] <= 24'h0;
         end
      end else if (doWrite && wAx) begin
         case (wFld)
            0: axCfg_ff[wAxIdx] <= 18'(merge(32'(axCfg_ff[wAxIdx]), wData_ff, wStrb_ff));
            1: valInt_ff[wAxIdx] <= merge(valInt_ff[wAxIdx], wData_ff, wStrb_ff);
            default: valFrac_ff[wAxIdx] <= 24'(merge(32'(valFrac_ff[wAxIdx]), wData_ff,
               wStrb_ff));
         endcase
      end
   end
   // ==========================================================
   // AXI4-Lite read channel
   logic [31:0] rdWord;
   logic rdHit, rAx;
   int rAxIdx, rFld;
   logic busy;
   always_comb rAx = decodeAxis({s_axi_araddr[11:2], 2'b00}, rAxIdx, rFld);
   assign s_axi_arready = !s_axi_rvalid;
   always_comb begin
      rdWord = 32'h0;
      rdHit = 1'b1;
      if (rAx) begin
         case (rFld)
            0: rdWord = 32'(axCfg_ff[rAxIdx]);
            1: rdWord = valInt_ff[rAxIdx];
            default: rdWord = 32'(valFrac_ff[rAxIdx]);
         endcase
      end else if ({s_axi_araddr[11:2], 2'b00} == `MVO_CTRL_OFS) begin
         rdWord = ctrl_ff;
      end else if ({s_axi_araddr[11:2], 2'b00} == `MVO_STAT_OFS) begin
         rdWord = {8'h0, sendCnt_ff, lastRx_ff, 6'h0, rxFault_ff, busy};
      end else begin
         rdHit = 1'b0;
      end
   end
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= 2'b00;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rdWord;
         s_axi_rresp <= rdHit ? 2'b00 : 2'b10;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
   // ==========================================================
   // Serial engine
   logic chValid, chReady, rxValid, rxErr;
   logic [7:0] chData, rxData;
   mvo_uart #(.CLK_HZ(CLK_HZ)) uUart (
      .clk(clk),
      .sys_rst(sys_rst),
      .frame(frame),
      .peerReady(rdySync_ff[1]), // RQ17
      .txValid(chValid),
      .txData(chData),
      .txReady(chReady),
      .txd(serTxd),
      .rxd(rxdSync_ff[1]),
      .rxValid(rxValid),
      .rxData(rxData),
      .rxErr(rxErr)
   );
   // The receiver never stalls, so it always reports ready; no flow control is spoken.
   assign rxReady = 1'b1; // RQ11 RQ13
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         lastRx_ff <= 8'h0;
         rxFault_ff <= 1'b0;
      end else begin
         if (rxValid) begin
            lastRx_ff <= rxData;
         end
         // A new fault in the clearing cycle wins over the clear.
         rxFault_ff <= rxErr || (rxFault_ff && !statClear);
      end
   end
   // ==========================================================
   // Record framer
   mvo_pkg::mvo_state_t st_ff;
   logic [1:0] axis_ff;
   logic [3:0] dig_ff, tail_ff;
   logic trigger, fire;
   logic [17:0] cfg;
   logic rot, dtg;
   logic [3:0] nInt, nFrac, nib;
   function automatic logic [3:0] clampDig(input logic [3:0] v, input logic [3:0] lo,
      input logic [3:0] hi);
      return (v < lo) ? lo : (v > hi) ? hi : v;
   endfunction : clampDig
   assign trigger = (swSync_ff[1] && !swLast_ff) || swTrig
      || (rxValid && rxData == `MVO_CTRL_B); // RQ1 RQ18
   assign busy = st_ff != mvo_pkg::ST_IDLE;
   assign cfg = axCfg_ff[axis_ff];
   assign rot = cfg[`MVO_ROT_BIT];
   assign dtg = ctrl_ff[`MVO_DTG_BIT];
   assign nInt = rot ? clampDig(cfg[14:11], 4'h4, 4'h8)
      : clampDig(cfg[14:11], 4'h2, 4'h7); // RQ3 RQ8
   assign nFrac = rot ? clampDig({1'b0, cfg[17:15]}, 4'h0, 4'h4)
      : clampDig({1'b0, cfg[17:15]}, 4'h1, 4'h6); // RQ4 RQ8
   assign nib = (st_ff == mvo_pkg::ST_INT) ? valInt_ff[axis_ff][dig_ff * 4 +: 4]
      : valFrac_ff[axis_ff][(4'h5 - dig_ff) * 4 +: 4];
   assign chValid = busy;
   assign fire = chValid && chReady;
   always_comb begin
      case (st_ff)
         mvo_pkg::ST_LETTER: chData = cfg[7:0]; // RQ2
         mvo_pkg::ST_EQ: chData = 8'h3d; // RQ2
         mvo_pkg::ST_SIGN: chData = cfg[`MVO_NEG_BIT] ? 8'h2d : 8'h2b; // RQ2
         mvo_pkg::ST_INT, mvo_pkg::ST_FRAC: chData = {4'h3, nib}; // RQ10
         mvo_pkg::ST_DP: chData = 8'h2e; // RQ3
         mvo_pkg::ST_UNIT: chData = (!rot && ctrl_ff[`MVO_INCH_BIT]) ? 8'h22 : 8'h20; // RQ5 RQ9
         mvo_pkg::ST_KIND: chData = rot ? (dtg ? 8'h77 : 8'h57) // RQ9
            : cfg[`MVO_DIA_BIT] ? (dtg ? 8'h64 : 8'h44) : (dtg ? 8'h72 : 8'h52); // RQ6
         mvo_pkg::ST_LF: chData = `MVO_LF; // RQ7
         default: chData = `MVO_CR; // RQ7 RQ16
      endcase
   end
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         st_ff <= mvo_pkg::ST_IDLE;
         axis_ff <= 2'h0;
         dig_ff <= 4'h0;
         tail_ff <= 4'h0;
         sendCnt_ff <= 8'h0;
      end else if (!busy) begin
         if (trigger) begin
            st_ff <= mvo_pkg::ST_LETTER; // RQ1
            axis_ff <= 2'h0;
            sendCnt_ff <= sendCnt_ff + 8'h1;
         end
      end else if (fire) begin
         case (st_ff)
            mvo_pkg::ST_LETTER: st_ff <= mvo_pkg::ST_EQ;
            mvo_pkg::ST_EQ: st_ff <= mvo_pkg::ST_SIGN;
            mvo_pkg::ST_SIGN: begin
               st_ff <= mvo_pkg::ST_INT;
               dig_ff <= nInt - 4'h1;
            end
            mvo_pkg::ST_INT: begin
               dig_ff <= dig_ff - 4'h1;
               if (dig_ff == 4'h0) begin
                  st_ff <= mvo_pkg::ST_DP;
               end
            end
            mvo_pkg::ST_DP: begin
               dig_ff <= 4'h0;
               st_ff <= (nFrac == 4'h0) ? mvo_pkg::ST_UNIT : mvo_pkg::ST_FRAC; // RQ8
            end
            mvo_pkg::ST_FRAC: begin
               dig_ff <= dig_ff + 4'h1;
               if (dig_ff == nFrac - 4'h1) begin
                  st_ff <= mvo_pkg::ST_UNIT;
               end
            end
            mvo_pkg::ST_UNIT: st_ff <= mvo_pkg::ST_KIND;
            mvo_pkg::ST_KIND: st_ff <= mvo_pkg::ST_CR;
            mvo_pkg::ST_CR: st_ff <= mvo_pkg::ST_LF;
            mvo_pkg::ST_LF: begin
               if (32'(axis_ff) < NUM_AXES - 1 && axis_ff < ctrl_ff[15:14] - 2'h1) begin
                  axis_ff <= axis_ff + 2'h1; // RQ19
                  st_ff <= mvo_pkg::ST_LETTER;
               end else if (ctrl_ff[11:8] != 4'h0) begin
                  tail_ff <= (ctrl_ff[11:8] > 4'h9) ? 4'h9 : ctrl_ff[11:8]; // RQ16
                  st_ff <= mvo_pkg::ST_TAIL;
               end else begin
                  st_ff <= mvo_pkg::ST_IDLE;
               end
            end
            mvo_pkg::ST_TAIL: begin
               tail_ff <= tail_ff - 4'h1;
               if (tail_ff == 4'h1) begin
                  st_ff <= mvo_pkg::ST_IDLE;
               end
            end
            default: st_ff <= mvo_pkg::ST_IDLE;
         endcase
      end
   end
endmodule : mvo_serial_out

// [core/mvo_uart.sv]
// Asynchronous character transmitter and receiver with selectable framing and rate.
`timescale 1ns/10ps
`include "mvo_map.svh"
module mvo_uart #(
   parameter int CLK_HZ = `MVO_CLK_HZ
) (
   input wire logic clk, // System clock.
   input wire logic sys_rst, // Synchronous reset, active high.
   input wire mvo_pkg::mvo_frame_t frame, // Rate and framing.
   input wire logic peerReady, // Synchronised far-end ready.
   input wire logic txValid, // Character offered.
   input wire logic [7:0] txData, // Character to send.
   output logic txReady, // Character taken when valid.
   output logic txd, // Serial output, idle high.
   input wire logic rxd, // Synchronised serial input.
   output logic rxValid, // One-cycle pulse, character received.
   output logic [7:0] rxData, // Received character.
   output logic rxErr // One-cycle pulse, framing or parity fault.
);
   initial if (CLK_HZ < 2000000) $error("mvo_uart: clock too slow for 115200 baud");
   // ==========================================================
   // Helpers
   function automatic logic [19:0] baudDiv(input logic [3:0] sel);
      int rate;
      case (sel)
         4'h0: rate = 300;
         4'h1: rate = 600;
         4'h2: rate = 1200;
         4'h3: rate = 2400;
         4'h4: rate = 9600;
         4'h5: rate = 19200;
         4'h6: rate = 38400;
         4'h7: rate = 57600;
         default: rate = 115200;
      endcase
      return 20'(CLK_HZ / rate - 1);
   endfunction : baudDiv
   function automatic logic parityOf(input logic [7:0] d, input mvo_pkg::mvo_frame_t f);
      logic p;
      p = f.eightBits ? ^d : ^d[6:0];
      return (f.parity == mvo_pkg::PAR_ODD) ? ~p : p;
   endfunction : parityOf
   logic [19:0] div;
   logic [3:0] nData, frameLen;
   logic hasPar;
   assign div = baudDiv(frame.baudSel);
   assign nData = frame.eightBits ? 4'h8 : 4'h7;
   assign hasPar = (frame.parity == mvo_pkg::PAR_EVEN) || (frame.parity == mvo_pkg::PAR_ODD);
   assign frameLen = 4'(1 + nData + hasPar + (frame.twoStop ? 2 : 1));
   // ==========================================================
   // Transmitter
   logic [11:0] txFrame, txSh_ff;
   logic [3:0] txLeft_ff;
   logic [19:0] txCnt_ff;
   always_comb begin
      txFrame = 12'hfff;
      txFrame[0] = 1'b0;
      for (int i = 0; i < 8; i++) begin
         if (i < nData) begin
            txFrame[i + 1] = txData[i];
         end
      end
      if (hasPar) begin
         txFrame[nData + 1] = parityOf(txData, frame);
      end
   end
   // A frame already started always completes; only the next start waits for the peer.
   assign txReady = (txLeft_ff == 4'h0) && peerReady;
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         txSh_ff <= 12'hfff;
         txLeft_ff <= 4'h0;
         txCnt_ff <= 20'h0;
      end else if (txValid && txReady) begin
         txSh_ff <= txFrame;
         txLeft_ff <= frameLen;
         txCnt_ff <= div;
      end else if (txLeft_ff != 4'h0) begin
         if (txCnt_ff == 20'h0) begin
            txSh_ff <= {1'b1, txSh_ff[11:1]};
            txLeft_ff <= txLeft_ff - 4'h1;
            txCnt_ff <= div;
         end else begin
            txCnt_ff <= txCnt_ff - 20'h1;
         end
      end
   end
   assign txd = (txLeft_ff == 4'h0) ? 1'b1 : txSh_ff[0];
   // ==========================================================
   // Receiver, sampling each bit at its centre
   logic [11:0] rxBits_ff;
   logic [3:0] rxIdx_ff;
   logic [19:0] rxCnt_ff;
   logic rxBusy_ff, rxDone_ff;
   logic [7:0] rxWord;
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rxBits_ff <= 12'h0;
         rxIdx_ff <= 4'h0;
         rxCnt_ff <= 20'h0;
         rxBusy_ff <= 1'b0;
         rxDone_ff <= 1'b0;
      end else begin
         rxDone_ff <= 1'b0;
         if (!rxBusy_ff) begin
            if (!rxd) begin
               rxBusy_ff <= 1'b1;
               rxIdx_ff <= 4'h0;
               rxCnt_ff <= {1'b0, div[19:1]};
            end
         end else if (rxCnt_ff != 20'h0) begin
            rxCnt_ff <= rxCnt_ff - 20'h1;
         end else begin
            rxBits_ff[rxIdx_ff] <= rxd;
            rxCnt_ff <= div;
            rxIdx_ff <= rxIdx_ff + 4'h1;
            if (rxIdx_ff == frameLen - 4'h1) begin
               rxBusy_ff <= 1'b0;
               rxDone_ff <= 1'b1;
            end
         end
      end
   end
   assign rxWord = frame.eightBits ? rxBits_ff[8:1] : {1'b0, rxBits_ff[7:1]};
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rxValid <= 1'b0;
         rxErr <= 1'b0;
         rxData <= 8'h0;
      end else begin
         rxValid <= 1'b0;
         rxErr <= 1'b0;
         if (rxDone_ff) begin
            rxData <= rxWord;
            if (rxBits_ff[0] || !rxBits_ff[1 + nData + hasPar]
                  || (hasPar && rxBits_ff[nData + 1] != parityOf(rxWord, frame))) begin
               rxErr <= 1'b1;
            end else begin
               rxValid <= 1'b1;
            end
         end
      end
   end
endmodule : mvo_uart

// [dv/mvo_peer_model.sv]
// Terminal model: captures the readout's characters and sends control codes.
`timescale 1ns/10ps
module mvo_peer_model #(
   parameter int BIT = 20
) (
   input wire logic clk, // Clock.
   input wire logic txd, // Line from the readout.
   input wire logic rxReady, // Readout accepts input.
   output logic rxd, // Line to the readout.
   output logic peerReady // High while capturing.
);
   logic [7:0] got[$];
   logic [7:0] sh;
   initial begin
      rxd = 1'b1;
      peerReady = 1'b1;
   end
   // A broken stop bit is stored as zero so that the bench sees it.
   always begin
      @(negedge txd);
      repeat (BIT / 2) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
         repeat (BIT) @(posedge clk);
         sh = {txd, sh[7:1]};
      end
      repeat (BIT) @(posedge clk);
      got.push_back(txd ? sh : 8'h00);
   end
   task setReady(input logic v);
      @(posedge clk);
      peerReady <= v;
   endtask : setReady
   task automatic sendByte(input logic [7:0] b);
      wait (rxReady);
      @(posedge clk);
      rxd <= 1'b0;
      repeat (BIT) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
         rxd <= b[i];
         repeat (BIT) @(posedge clk);
      end
      rxd <= 1'b1;
      repeat (BIT) @(posedge clk);
   endtask : sendByte
endmodule : mvo_peer_model

// [dv/mvo_serial_out_properties.sv]
// Assertions on the bus and line ports of the measured-value serial output.
`timescale 1ns/10ps
module mvo_serial_out_chk (
   input wire logic clk, // Clock.
   input wire logic sys_rst, // Reset.
   input wire logic [11:0] s_axi_awaddr, // Write address.
   input wire logic s_axi_awvalid, // Address valid.
   input wire logic s_axi_awready, // Address ready.
   input wire logic s_axi_wvalid, // Data valid.
   input wire logic s_axi_wready, // Data ready.
   input wire logic [1:0] s_axi_bresp, // Write response.
   input wire logic s_axi_bvalid, // Response valid.
   input wire logic s_axi_bready, // Response ready.
   input wire logic s_axi_arvalid, // Read valid.
   input wire logic s_axi_arready, // Read ready.
   input wire logic s_axi_rvalid, // Read data valid.
   input wire logic s_axi_rready, // Read data ready.
   input wire logic serTxd // Serial output.
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   // ==========================================================
   // Handshakes
   sequence s_wtake;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   property p_bnext; s_wtake |-> ##2 s_axi_bvalid; endproperty
   a_bnext: assert property (p_bnext) else $error("write response late");
   property p_badaddr;
      s_wtake ##0 (s_axi_awaddr == 12'hffc) |-> ##2 s_axi_bresp == 2'b10;
   endproperty
   a_badaddr: assert property (p_badaddr) else $error("unmapped write not refused");
   property p_bblock; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
   a_bblock: assert property (p_bblock) else $error("write taken during response");
   property p_bdone; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
   a_bdone: assert property (p_bdone) else $error("write response repeated");
   property p_rnext; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
   a_rnext: assert property (p_rnext) else $error("read data late");
   property p_rblock; s_axi_rvalid |-> !s_axi_arready; endproperty
   a_rblock: assert property (p_rblock) else $error("read taken during answer");
   property p_rdone; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
   a_rdone: assert property (p_rdone) else $error("read answer repeated");
   // A trigger cannot reach the line this soon, so the line must rest at mark.
   property p_idle; $fell(sys_rst) |-> serTxd [*3]; endproperty
   a_idle: assert property (p_idle) else $error("line not idle after reset");
endmodule : mvo_serial_out_chk
bind mvo_serial_out mvo_serial_out_chk chk_u (.*);

// [dv/test_mvo_serial_out.sv]
// Self-checking bench for the measured-value serial output.
`timescale 1ns/10ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin failures++; \
   $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module test_mvo_serial_out;
   localparam int HZ = 2304000;
   logic clk = 1'b0, sys_rst = 1'b1, remoteSwitch = 1'b0;
   logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic serRxd, peerReady, serTxd, rxReady;
   int checks = 0, failures = 0;
   always #2.5 clk = ~clk;
   // A lowered clock figure gives 20 cycles a bit at the fastest rate.
   mvo_serial_out #(.CLK_HZ(HZ)) dut_u (.*);
   mvo_peer_model #(.BIT(HZ / 115200)) peer_u (.clk(clk), .txd(serTxd), .rxReady(rxReady),
      .rxd(serRxd), .peerReady(peerReady));
   task finish_test;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : finish_test
   task bound(input int n);
      if (n >= 5000) begin failures++; finish_test(); end
   endtask : bound
   task automatic axiWr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er = 2'b00);
      logic aw, w;
      int n;
      aw = 1'b1; w = 1'b1; n = 0;
      @(posedge clk);
      s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_bready <= 1'b1;
      s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         if (aw && s_axi_awready) begin aw = 1'b0; s_axi_awvalid <= 1'b0; end
         if (w && s_axi_wready) begin w = 1'b0; s_axi_wvalid <= 1'b0; end
      end while (!(s_axi_bvalid && !aw && !w) && n < 5000);
      s_axi_bready <= 1'b0;
      bound(n);
      `CHK(s_axi_bresp, er)
   endtask : axiWr
   task automatic axiRd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er = 2'b00);
      int n;
      n = 0;
      @(posedge clk);
      s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid && n < 5000);
      s_axi_rready <= 1'b0;
      bound(n);
      `CHK(s_axi_rresp, er)
      if (er == 2'b00) `CHK(s_axi_rdata, ed)
   endtask : axiRd
   task automatic expectStr(input string s);
      int n;
      logic [7:0] c;
      for (int i = 0; i < s.len(); i++) begin
         n = 0;
         while (peer_u.got.size() == 0 && n < 5000) begin @(posedge clk); n++; end
         bound(n);
         c = peer_u.got.pop_front();
         `CHK(c, s[i])
      end
   endtask : expectStr
   initial begin
      repeat (20) @(posedge clk);
      sys_rst <= 1'b0;
      axiRd(12'h000, 32'h0000_c084);
      axiRd(12'h014, 32'h0);
      axiWr(12'hffc, 32'h1, 2'b10);
      axiRd(12'hffc, 32'h0, 2'b10);
      $display("test registers done");
      axiWr(12'h000, 32'h0000_8282);
      axiWr(12'h010, 32'h0001_1058);
      axiWr(12'h014, 32'h0000_0041);
      axiWr(12'h018, 32'h0029_0000);
      axiWr(12'h020, 32'h0000_2143);
      axiWr(12'h024, 32'h0000_1260);
      peer_u.setReady(1'b0);
      @(posedge clk);
      remoteSwitch <= 1'b1;
      repeat (300) @(posedge clk);
      remoteSwitch <= 1'b0;
      `CHK(peer_u.got.size(), 0)
      peer_u.setReady(1'b1);
      expectStr("X=+41.29 R\015\012");
      expectStr("C=+1260. W\015\012\015\015");
      repeat (600) @(posedge clk);
      `CHK(peer_u.got.size(), 0)
      $display("test switch output done");
      axiWr(12'h010, 32'h0003_3e58);
      axiWr(12'h000, 32'h0000_b982);
      peer_u.sendByte(8'h02);
      expectStr("X=-0000041.290000\"d\015\012C=+1260. w\015\012");
      expectStr("\015\015\015\015\015\015\015\015\015");
      repeat (600) @(posedge clk);
      `CHK(peer_u.got.size(), 0)
      axiWr(12'h000, 32'h0001_4082);
      expectStr("X=-0000041.290000 D\015\012");
      axiRd(12'h000, 32'h0000_4082);
      axiRd(12'h004, 32'h0003_0200);
      $display("test control code output done");
      finish_test();
   end
endmodule : test_mvo_serial_out

// [shared/mvo_map.svh]
// Register map, field positions, reset values and timing for the measured-value output.
`ifndef MVO_MAP_SVH
`define MVO_MAP_SVH
// ==========================================================
// Register byte offsets
`define MVO_CTRL_OFS 12'h000
`define MVO_STAT_OFS 12'h004
`define MVO_AXIS_BASE 12'h010
`define MVO_AXIS_STEP 12'h010
// ==========================================================
// Control fields
`define MVO_CTRL_RST 32'h0000_c084
`define MVO_TRIG_BIT 16
`define MVO_INCH_BIT 12
`define MVO_DTG_BIT 13
// ==========================================================
// Axis configuration fields
`define MVO_NEG_BIT 10
`define MVO_ROT_BIT 8
`define MVO_DIA_BIT 9
// ==========================================================
// Characters and timing
`define MVO_CTRL_B 8'h02
`define MVO_CR 8'h0d
`define MVO_LF 8'h0a
`define MVO_CLK_HZ 200000000
`endif

// [shared/mvo_pkg.sv]
// Types shared by the measured-value output core and its serial engine.
package mvo_pkg;
   typedef enum logic [1:0] {PAR_NONE, PAR_EVEN, PAR_ODD, PAR_RSV} mvo_parity_t;
   typedef struct packed {
      logic [3:0] baudSel;
      mvo_parity_t parity;
      logic eightBits;
      logic twoStop;
   } mvo_frame_t;
   typedef enum {ST_IDLE, ST_LETTER, ST_EQ, ST_SIGN, ST_INT, ST_DP, ST_FRAC, ST_UNIT,
      ST_KIND, ST_CR, ST_LF, ST_TAIL} mvo_state_t;
endpackage : mvo_pkg
